// >>> sbc_event_pkg.sv
package sbc_event_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_MHZ      = 50;   // pclk rate
  localparam int unsigned PULSE_US     = 100;  // Nominal pulse width
  localparam int unsigned GAP_US       = 100;  // Nominal pulse_gap_time
  localparam int unsigned CFG_FILT_US  = 10;   // Nominal config select filter
  localparam int unsigned PULSE_CYC    = PULSE_US * CLK_MHZ;
  localparam int unsigned GAP_CYC      = GAP_US * CLK_MHZ;
  localparam int unsigned CFG_FILT_CYC = CFG_FILT_US * CLK_MHZ;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_WAKE_EN   = 8'h04;
  localparam logic [7:0] OFS_WS_ONE    = 8'h08;
  localparam logic [7:0] OFS_WS_TWO    = 8'h0c;
  localparam logic [7:0] OFS_FAIL      = 8'h10;
  localparam logic [7:0] OFS_DEV       = 8'h14;
  localparam logic [7:0] OFS_PIN_LVL   = 8'h18;

  // ==========================================================================
  // Fields and reset values
  localparam int unsigned CTRL_CLASS_BIT = 0;
  localparam int unsigned DEV_POR_BIT    = 0;
  localparam int unsigned DEV_CFG_BIT    = 1;
  localparam int unsigned DEV_MODE_LSB   = 2;
  localparam int unsigned FAIL_UNDER_BIT = 0;  // supply_under_flag
  localparam int unsigned FAIL_WD_BIT    = 1;  // watchdog_fail_flag
  localparam int unsigned FAIL_SHORT_BIT = 2;  // supply_short_flag
  localparam int unsigned FAIL_THERMAL_STAGE_TWO_FLAG_BIT  = 3;  // thermal_stage_two_flag
  localparam int unsigned FAIL_FO_BIT    = 4;  // fail-output flag
  localparam logic [7:0]  FAIL_NO_INT_MASK = 8'h1f;
  localparam logic        CLASS_RST      = 1'h0;
  localparam logic [15:0] WAKE_EN_RST    = 16'h0000;
  localparam logic        POR_RST        = 1'h1;
  localparam logic        CFG_SEL_RST    = 1'h0;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    mode_init,
    mode_normal,
    mode_stop,
    mode_sleep,
    mode_restart,
    mode_fail_safe
  } mode_type;

  typedef struct packed {
    logic [15:0] wake;     // Wake sources; [7:0] one, [15:8] two
    logic [7:0]  fail;     // Failure detectors
    logic [7:0]  level;    // Live pin levels
    logic        int_pin;  // Event pin read-back
  } pin_in_type;

endpackage

// >>> sync_two_ff.sv
`timescale 1ns/1ns
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input  logic             clk,    // Destination clock
  input  logic             rst_n,  // Async reset, active low
  input  logic [WIDTH-1:0] d,      // Asynchronous input
  output logic [WIDTH-1:0] q       // Synchronised output
);

  logic [WIDTH-1:0] meta_q;

  // First stage is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // sync_two_ff

// >>> event_pulse_signaller.sv
`timescale 1ns/1ns
// What this block does
// - In normal or stop mode each event drives the pin low one pulse width.
// - Pin stays high at least the gap time between pulses.
// - A pulse never changes the operating mode.
// - Class select at 0 lets only wake status events pulse.
// - A wake event pulses only if its source is enabled.
// - Class select at 1 adds failure flags; pin level status never pulses.
// - Undervoltage, watchdog, short, thermal two and fail-output flags never pulse.
// - Power-on flag and device status never pulse.
// - Stop command with any wake status bit set raises a pulse.
// - Readable status updates at each pulse falling edge.
// - Events stay latched until software clears them.
// - In init mode the pin is a filtered configuration input.
module event_pulse_signaller #(
  parameter int unsigned PULSE_CYC = sbc_event_pkg::PULSE_CYC, // Pulse width cycles
  parameter int unsigned GAP_CYC   = sbc_event_pkg::GAP_CYC    // Least gap cycles
) (
  input  logic                      pclk,        // APB clock, 50 MHz
  input  logic                      presetn,     // Async reset, active low
  input  logic                      psel,        // APB select
  input  logic                      penable,     // APB enable
  input  logic                      pwrite,      // APB direction
  input  logic [7:0]                paddr,       // APB byte address
  input  logic [31:0]               pwdata,      // APB write data
  output logic [31:0]               prdata,      // APB read data
  output logic                      pready,      // APB ready
  output logic                      pslverr,     // APB error, unmapped address
  input  sbc_event_pkg::mode_type   mode,        // Operating mode, same clock
  input  logic                      stop_cmd_ok, // Stop command accepted, pulse
  input  sbc_event_pkg::pin_in_type pins,        // Asynchronous pin inputs
  output logic                      int_o,       // Event pin output level
  output logic                      int_oe_n,    // Event pin driver enable, low
  output logic                      config_sel   // Filtered configuration level
);

  typedef enum logic [1:0] {st_idle, st_pulse, st_gap} state_type;

  localparam logic [15:0] PULSE_LAST = 16'(PULSE_CYC - 1);
  localparam logic [15:0] GAP_LAST   = 16'(GAP_CYC - 1);
  localparam logic [15:0] CFG_LAST   = 16'(sbc_event_pkg::CFG_FILT_CYC - 1);

  // ==========================================================================
  // Input synchronisation
  localparam int PIN_W = $bits(sbc_event_pkg::pin_in_type);

  logic [PIN_W-1:0]          pins_s;
  sbc_event_pkg::pin_in_type pins_r;
  logic [15:0]               wake_prev_q;
  logic [7:0]                fail_prev_q;
  wire  [15:0]               wake_new;
  wire  [7:0]                fail_new;

  sync_two_ff #(.WIDTH(PIN_W)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (pins),
    .q     (pins_s)
  );

  assign pins_r   = pins_s;
  assign wake_new = pins_r.wake & ~wake_prev_q;
  assign fail_new = pins_r.fail & ~fail_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_prev_q <= 16'h0000;
      fail_prev_q <= 8'h00;
    end else begin
      wake_prev_q <= pins_r.wake;
      fail_prev_q <= pins_r.fail;
    end
  end

  // ==========================================================================
  // APB decode
  logic        class_q;
  logic [15:0] wake_en_q;
  logic        por_q;
  logic [7:0]  hid_ws1_q, hid_ws2_q, hid_fail_q;
  logic [7:0]  vis_ws1_q, vis_ws2_q, vis_fail_q;
  logic [7:0]  hid_ws1_d, hid_ws2_d, hid_fail_d;
  logic [7:0]  vis_ws1_d, vis_ws2_d, vis_fail_d;
  logic [31:0] rd_data;
  logic        hit;

  wire setup    = psel & ~penable;
  wire wr_en    = psel & penable & pwrite & pready & hit;
  wire sel_ctrl = (paddr == sbc_event_pkg::OFS_CTRL);
  wire sel_wen  = (paddr == sbc_event_pkg::OFS_WAKE_EN);
  wire sel_ws1  = (paddr == sbc_event_pkg::OFS_WS_ONE);
  wire sel_ws2  = (paddr == sbc_event_pkg::OFS_WS_TWO);
  wire sel_fail = (paddr == sbc_event_pkg::OFS_FAIL);
  wire sel_dev  = (paddr == sbc_event_pkg::OFS_DEV);
  wire sel_lvl  = (paddr == sbc_event_pkg::OFS_PIN_LVL);

  // Write one to clear; a set in the same cycle wins
  wire [7:0] clr_ws1  = (wr_en && sel_ws1) ? pwdata[7:0] : 8'h00;
  wire [7:0] clr_ws2  = (wr_en && sel_ws2) ? pwdata[7:0] : 8'h00;
  wire [7:0] clr_fail = (wr_en && sel_fail) ? pwdata[7:0] : 8'h00;
  wire       clr_por  = wr_en && sel_dev && pwdata[sbc_event_pkg::DEV_POR_BIT];

  assign hit = sel_ctrl | sel_wen | sel_ws1 | sel_ws2 | sel_fail | sel_dev | sel_lvl;

  always_comb begin
    rd_data = 32'h0000_0000;
    case (1'b1)
      sel_ctrl: rd_data[sbc_event_pkg::CTRL_CLASS_BIT] = class_q;
      sel_wen:  rd_data[15:0] = wake_en_q;
      sel_ws1:  rd_data[7:0]  = vis_ws1_q;
      sel_ws2:  rd_data[7:0]  = vis_ws2_q;
      sel_fail: rd_data[7:0]  = vis_fail_q;
      sel_dev: begin
        rd_data[sbc_event_pkg::DEV_POR_BIT] = por_q;
        rd_data[sbc_event_pkg::DEV_CFG_BIT] = config_sel;
        rd_data[sbc_event_pkg::DEV_MODE_LSB +: 3] = mode;
      end
      sel_lvl:  rd_data[7:0]  = pins_r.level;  // Live, never latched
      default:  rd_data = 32'h0000_0000;
    endcase
  end

  // Zero wait states: ready is high in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= (setup && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      class_q   <= sbc_event_pkg::CLASS_RST;
      wake_en_q <= sbc_event_pkg::WAKE_EN_RST;
    end else if (wr_en) begin
      if (sel_ctrl) class_q <= pwdata[sbc_event_pkg::CTRL_CLASS_BIT];
      if (sel_wen) wake_en_q <= pwdata[15:0];
    end
  end

  // ==========================================================================
  // Event triggers
  state_type   st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic        pending_q;

  wire act       = (mode == sbc_event_pkg::mode_normal) || (mode == sbc_event_pkg::mode_stop);
  // Device status and power-on flag feed no trigger at all
  wire wake_trig = |(wake_new & wake_en_q);
  wire fail_trig = class_q & |(fail_new & ~sbc_event_pkg::FAIL_NO_INT_MASK);
  wire stop_trig = stop_cmd_ok & ((|hid_ws1_q) | (|hid_ws2_q));
  wire trig      = act & (wake_trig | fail_trig | stop_trig);
  wire start     = (st_q == st_idle) & act & pending_q;
  wire snap      = (st_q == st_idle);

  // Hidden copies latch at once; visible copies follow them only while idle,
  // so a read during a pulse shows what caused it
  assign hid_ws1_d  = (hid_ws1_q & ~clr_ws1) | wake_new[7:0];
  assign hid_ws2_d  = (hid_ws2_q & ~clr_ws2) | wake_new[15:8];
  assign hid_fail_d = (hid_fail_q & ~clr_fail) | fail_new;
  assign vis_ws1_d  = snap ? hid_ws1_d : (vis_ws1_q & ~clr_ws1);
  assign vis_ws2_d  = snap ? hid_ws2_d : (vis_ws2_q & ~clr_ws2);
  assign vis_fail_d = snap ? hid_fail_d : (vis_fail_q & ~clr_fail);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hid_ws1_q  <= 8'h00;
      hid_ws2_q  <= 8'h00;
      hid_fail_q <= 8'h00;
      vis_ws1_q  <= 8'h00;
      vis_ws2_q  <= 8'h00;
      vis_fail_q <= 8'h00;
      por_q      <= sbc_event_pkg::POR_RST;
    end else begin
      hid_ws1_q  <= hid_ws1_d;
      hid_ws2_q  <= hid_ws2_d;
      hid_fail_q <= hid_fail_d;
      vis_ws1_q  <= vis_ws1_d;
      vis_ws2_q  <= vis_ws2_d;
      vis_fail_q <= vis_fail_d;
      por_q      <= por_q & ~clr_por;
    end
  end

  // ==========================================================================
  // Pulse sequencer
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q + 16'h0001;
    case (st_q)
      st_idle: begin
        cnt_d = 16'h0000;
        if (start) st_d = st_pulse;
      end
      st_pulse: begin
        if (cnt_q == PULSE_LAST) begin
          st_d  = st_gap;
          cnt_d = 16'h0000;
        end
      end
      st_gap: begin
        if (cnt_q == GAP_LAST) begin
          st_d  = st_idle;
          cnt_d = 16'h0000;
        end
      end
      default: begin
        st_d  = st_idle;
        cnt_d = 16'h0000;
      end
    endcase
    if (!act) begin
      st_d  = st_idle;
      cnt_d = 16'h0000;
    end
  end

  // Mode is only read here; nothing drives it back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= st_idle;
      cnt_q     <= 16'h0000;
      pending_q <= 1'b0;
      int_o     <= 1'b1;
      int_oe_n  <= 1'b1;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      pending_q <= act & (trig | (pending_q & ~start));
      int_o     <= (st_d != st_pulse);
      int_oe_n  <= (mode == sbc_event_pkg::mode_init);
    end
  end

  // ==========================================================================
  // Configuration select filter, init mode only
  logic [15:0] cfg_cnt_q;

  wire cfg_diff = (pins_r.int_pin != config_sel);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_cnt_q  <= 16'h0000;
      config_sel <= sbc_event_pkg::CFG_SEL_RST;
    end else if (mode != sbc_event_pkg::mode_init || !cfg_diff) begin
      cfg_cnt_q <= 16'h0000;
    end else if (cfg_cnt_q == CFG_LAST) begin
      cfg_cnt_q  <= 16'h0000;
      config_sel <= pins_r.int_pin;
    end else begin
      cfg_cnt_q <= cfg_cnt_q + 16'h0001;
    end
  end

  // ==========================================================================
  // Checks
  logic [15:0] lo_cnt_q, hi_cnt_q, act_run_q, stop_wait_q;

  // Stop request seen with wake status latched; built apart from the trigger path
  wire stop_seen = act && stop_cmd_ok && ((hid_ws1_q != 8'h00) || (hid_ws2_q != 8'h00));
  wire int_fell  = !int_o && (hi_cnt_q != 16'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_cnt_q    <= 16'h0000;
      hi_cnt_q    <= 16'hffff;
      act_run_q   <= 16'h0000;
      stop_wait_q <= 16'h0000;
    end else begin
      lo_cnt_q  <= int_o ? 16'h0000 : lo_cnt_q + 16'h0001;
      hi_cnt_q  <= !int_o ? 16'h0000 : (&hi_cnt_q ? hi_cnt_q : hi_cnt_q + 16'h0001);
      act_run_q <= !act ? 16'h0000 : (&act_run_q ? act_run_q : act_run_q + 16'h0001);
      // Counts from a stop request to the next falling edge of the pin
      if (!act) begin
        stop_wait_q <= 16'h0000;
      end else if (int_fell || (stop_wait_q == 16'h0000)) begin
        stop_wait_q <= {15'h0000, stop_seen};
      end else if (!(&stop_wait_q)) begin
        stop_wait_q <= stop_wait_q + 16'h0001;
      end
    end
  end

  sequence pulse_begin_s;
    $fell(int_o);
  endsequence

  sequence pulse_end_s;
    $rose(int_o) && (act_run_q > 16'(PULSE_CYC + 2));
  endsequence

  pulse_width_a: assert property (@(posedge pclk) disable iff (!presetn)
    pulse_end_s |-> lo_cnt_q == 16'(PULSE_CYC))
    else $error("event pulse width wrong");

  gap_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    pulse_begin_s |-> hi_cnt_q >= 16'(GAP_CYC))
    else $error("gap between pulses too short");

  quiet_inactive_a: assert property (@(posedge pclk) disable iff (!presetn)
    !act |=> int_o)
    else $error("pulse outside normal or stop mode");

  snap_status_a: assert property (@(posedge pclk) disable iff (!presetn)
    pulse_begin_s |-> (vis_ws1_q == hid_ws1_q) && (vis_fail_q == hid_fail_q))
    else $error("status not updated at pulse start");

  no_excluded_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == st_idle) && !pending_q && !wake_trig && !stop_trig
      && ((fail_new & ~sbc_event_pkg::FAIL_NO_INT_MASK) == 8'h00)
      |=> !pending_q ##1 int_o)
    else $error("excluded flag raised a pulse");

  wake_class_a: assert property (@(posedge pclk) disable iff (!presetn)
    act && !class_q && (fail_new != 8'h00) && !wake_trig && !stop_trig
      && !pending_q |=> !pending_q)
    else $error("failure pulsed in wake class");

  stop_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    stop_wait_q <= 16'(PULSE_CYC + GAP_CYC + 8))
    else $error("stop command with wake status gave no pulse");

  sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && sel_ws1) |=> (hid_ws1_q & $past(hid_ws1_q)) == $past(hid_ws1_q))
    else $error("status bit lost without clear");

  held_pending_a: assert property (@(posedge pclk) disable iff (!presetn)
    act && trig && (st_q != st_idle) |=> pending_q)
    else $error("event during pulse or gap dropped");

  init_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == sbc_event_pkg::mode_init) |=> int_oe_n && int_o)
    else $error("event pin driven in init mode");

endmodule // event_pulse_signaller

// >>> host_apb_model.sv
`timescale 1ns/1ns
// ======================================
// Host register master on the bus side
module host_apb_model (
  input  wire logic        pclk,    // Bus clock
  output logic             psel,    // Select
  output logic             penable, // Enable
  output logic             pwrite,  // Direction
  output logic [7:0]       paddr,   // Byte address
  output logic [31:0]      pwdata,  // Write data
  input  wire logic [31:0] prdata,  // Read data
  input  wire logic        pready,  // Ready
  input  wire logic        pslverr  // Error
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // Starts on its own edge, so back-to-back calls never drive psel twice in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No own limit: only the bench timeout ends a wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Clear by writing ones, then read again to confirm the event is gone
  task automatic clear_confirm(input logic [7:0] a, input logic [31:0] m,
                               output logic [31:0] q);
    logic e;
    xfer(1'b1, a, m, q, e);
    xfer(1'b0, a, 32'h0, q, e);
  endtask
endmodule // host_apb_model

// >>> tb_top.sv
`timescale 1ns/1ns
// ======================================
// Bench top
module tb_top;
  localparam int unsigned PW = 20; // Shortened pulse width
  localparam int unsigned GW = 20; // Shortened gap
  logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                      stop_cmd_ok, int_o, int_oe_n, config_sel, cfg_level;
  logic [7:0]                paddr, fail_d, lvl_d;
  logic [15:0]               wake_d;
  logic [31:0]               pwdata, prdata, q;
  sbc_event_pkg::mode_type   mode;
  sbc_event_pkg::pin_in_type pins_w;
  int                        failures, n_compared, cycles;

  // Event pin resolves to the external configuration level cfg_level while the driver is off
  assign pins_w = {wake_d, fail_d, lvl_d, (int_oe_n ? cfg_level : int_o)};

  event_pulse_signaller #(.PULSE_CYC(PW), .GAP_CYC(GW)) event_pulse_signaller_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode(mode), .stop_cmd_ok(stop_cmd_ok), .pins(pins_w),
    .int_o(int_o), .int_oe_n(int_oe_n), .config_sel(config_sel));

  host_apb_model host_apb_model_inst (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ======================================
  // Checking helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic er;
    host_apb_model_inst.xfer(1'b0, a, 32'h0, q, er);
    chk(nm, q, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic er;
    host_apb_model_inst.xfer(1'b1, a, d, q, er);
  endtask

  // Waits for a pulse, measures it, then lets the gap run out
  task automatic pulse_chk(input string nm, input logic seen);
    int n, w;
    n = 0;
    w = 0;
    while (int_o !== 1'b0 && n < 40) begin
      n++;
      @(posedge pclk);
    end
    while (int_o === 1'b0 && w < 100) begin
      w++;
      @(posedge pclk);
    end
    chk(nm, (n < 40), seen);
    if (seen) chk(nm, w, PW);
    repeat (GW + 2) @(posedge pclk);
  endtask

  task automatic lower_all();
    @(posedge pclk);
    wake_d <= 16'h0;
    fail_d <= 8'h0;
    lvl_d  <= 8'h0;
    repeat (4) @(posedge pclk);
  endtask

  // ======================================
  // Scenarios
  task automatic t_init();
    chk("init_oe_n", int_oe_n, 1'b1);
    @(posedge pclk);
    cfg_level <= 1'b1;
    repeat (400) @(posedge pclk);
    chk("cfg_early", config_sel, 1'b0);
    repeat (150) @(posedge pclk);
    chk("cfg_late", config_sel, 1'b1);
    rd_chk("dev_init", sbc_event_pkg::OFS_DEV, 32'h3);
    @(posedge pclk);
    mode <= sbc_event_pkg::mode_normal;
    repeat (3) @(posedge pclk);
    chk("run_oe_n", int_oe_n, 1'b0);
    chk("run_idle", int_o, 1'b1);
  endtask

  task automatic t_regs();
    logic e;
    rd_chk("ctrl_rst", sbc_event_pkg::OFS_CTRL, 32'h0);
    rd_chk("wen_rst", sbc_event_pkg::OFS_WAKE_EN, 32'h0);
    host_apb_model_inst.xfer(1'b0, 8'h1c, 32'h0, q, e);
    chk("unmapped", e, 1'b1);
  endtask

  task automatic t_wake();
    wr(sbc_event_pkg::OFS_WAKE_EN, 32'h0103);
    @(posedge pclk);
    wake_d[0] <= 1'b1;
    pulse_chk("wake_one", 1'b1);
    rd_chk("ws_one", sbc_event_pkg::OFS_WS_ONE, 32'h1);
    host_apb_model_inst.clear_confirm(sbc_event_pkg::OFS_WS_ONE, 32'h1, q);
    chk("ws_one_clr", q, 32'h0);
    @(posedge pclk);
    wake_d[8] <= 1'b1;
    pulse_chk("wake_two", 1'b1);
    rd_chk("ws_two", sbc_event_pkg::OFS_WS_TWO, 32'h1);
    @(posedge pclk);
    wake_d[2] <= 1'b1;
    pulse_chk("wake_off", 1'b0);
    rd_chk("ws_off", sbc_event_pkg::OFS_WS_ONE, 32'h4);
    host_apb_model_inst.clear_confirm(sbc_event_pkg::OFS_WS_ONE, 32'hff, q);
    host_apb_model_inst.clear_confirm(sbc_event_pkg::OFS_WS_TWO, 32'hff, q);
    lower_all();
  endtask

  task automatic t_merge();
    int n;
    n = 0;
    @(posedge pclk);
    wake_d[0] <= 1'b1;
    while (int_o !== 1'b0 && n < 40) begin
      n++;
      @(posedge pclk);
    end
    wake_d[1] <= 1'b1;
    rd_chk("frozen", sbc_event_pkg::OFS_WS_ONE, 32'h1);
    n = 0;
    while (int_o === 1'b0 && n < 100) begin
      n++;
      @(posedge pclk);
    end
    n = 0;
    while (int_o !== 1'b0 && n < 200) begin
      n++;
      @(posedge pclk);
    end
    chk("held", (n < 200), 1'b1);
    chk("gap", (n >= GW + 1), 1'b1);
    rd_chk("updated", sbc_event_pkg::OFS_WS_ONE, 32'h3);
    repeat (PW + GW + 4) @(posedge pclk);
    host_apb_model_inst.clear_confirm(sbc_event_pkg::OFS_WS_ONE, 32'h3, q);
    chk("merge_clr", q, 32'h0);
    lower_all();
  endtask

  task automatic t_class();
    int i;
    @(posedge pclk);
    fail_d[5] <= 1'b1;
    pulse_chk("fail_c0", 1'b0);
    rd_chk("fail_st", sbc_event_pkg::OFS_FAIL, 32'h20);
    wr(sbc_event_pkg::OFS_CTRL, 32'h1);
    lower_all();
    @(posedge pclk);
    fail_d[5] <= 1'b1;
    pulse_chk("fail_c1", 1'b1);
    host_apb_model_inst.clear_confirm(sbc_event_pkg::OFS_FAIL, 32'hff, q);
    chk("fail_clr", q, 32'h0);
    for (i = 0; i < 5; i++) begin
      @(posedge pclk);
      fail_d[i] <= 1'b1;
      pulse_chk("fail_excl", 1'b0);
    end
    @(posedge pclk);
    lvl_d <= 8'h5a;
    pulse_chk("level", 1'b0);
    rd_chk("lvl_live", sbc_event_pkg::OFS_PIN_LVL, 32'h5a);
    lower_all();
    rd_chk("lvl_gone", sbc_event_pkg::OFS_PIN_LVL, 32'h0);
    host_apb_model_inst.clear_confirm(sbc_event_pkg::OFS_FAIL, 32'hff, q);
    wr(sbc_event_pkg::OFS_CTRL, 32'h0);
  endtask

  task automatic t_stop();
    @(posedge pclk);
    wake_d[0] <= 1'b1;
    pulse_chk("stop_pre", 1'b1);
    @(posedge pclk);
    mode <= sbc_event_pkg::mode_stop;
    @(posedge pclk);
    stop_cmd_ok <= 1'b1;
    @(posedge pclk);
    stop_cmd_ok <= 1'b0;
    pulse_chk("stop_set", 1'b1);
    host_apb_model_inst.clear_confirm(sbc_event_pkg::OFS_WS_ONE, 32'hff, q);
    @(posedge pclk);
    stop_cmd_ok <= 1'b1;
    @(posedge pclk);
    stop_cmd_ok <= 1'b0;
    pulse_chk("stop_clr", 1'b0);
    @(posedge pclk);
    mode <= sbc_event_pkg::mode_normal;
  endtask

  // ======================================
  // Sequence and hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    failures    = 0;
    n_compared  = 0;
    cycles      = 0;
    presetn     = 1'b0;
    mode        = sbc_event_pkg::mode_init;
    stop_cmd_ok = 1'b0;
    cfg_level   = 1'b0;
    wake_d      = 16'h0;
    fail_d      = 8'h0;
    lvl_d       = 8'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_init();
    t_regs();
    t_wake();
    t_merge();
    t_class();
    t_stop();
    finish_test();
  end
endmodule // tb_top
